// File: src/rfant_regs.svh
/*
  register offsets, field positions, reset values and timing counts for the
  rf front-end antenna control block; assumes a 250 MHz mclk.
*/
`ifndef RFANT_REGS_SVH
`define RFANT_REGS_SVH
`define RFANT_OFS_RXCORR      8'h0a
`define RFANT_OFS_ANTSEL      8'h0d
`define RFANT_OFS_TRXCTL1     8'h04
`define RFANT_OFS_STATUS      8'h40
`define RFANT_THRES_RST       4'h7
`define RFANT_THRES_DIV       4'h3
`define RFANT_BIT_SELANT      7
`define RFANT_BIT_DIVEN       3
`define RFANT_BIT_SWEN        2
`define RFANT_BIT_FEEN        7
`define RFANT_BIT_TSEN        6
`define RFANT_TRXCTL1_RST     8'h22
`define RFANT_CLK_MHZ         250
`define RFANT_TX_ON_NS        6000
`define RFANT_TX_OFF_NS       3000
`define RFANT_TX_ON_CYC       ((`RFANT_TX_ON_NS * `RFANT_CLK_MHZ + 999) / 1000)
`define RFANT_TX_OFF_CYC      ((`RFANT_TX_OFF_NS * `RFANT_CLK_MHZ + 999) / 1000)
`endif

// File: src/rfant_pkg.sv
/*
  types of the rf front-end antenna control block; no assumptions.
*/
package rfant_pkg;
  typedef enum {RFANT_FE_IDLE, RFANT_FE_ON_WAIT, RFANT_FE_TX, RFANT_FE_OFF_WAIT} rfant_fe_e;
  typedef logic [7:0] rfant_addr_t;
  typedef logic [7:0] rfant_data_t;
endpackage

// File: src/rfant_delay.sv
/*
  one-shot delay counter: a start pulse yields a done pulse a fixed number
  of cycles later. assumes start from mclk logic.
*/
`timescale 1ns/1ps
module rfant_delay #(
  parameter int CYCLES = 4
) (
  input  wire logic mclk,  // clock
  input  wire logic nrst,  // sync reset, low
  input  wire logic start, // begin count
  input  wire logic abort, // cancel count
  output logic      done   // end pulse
);
  logic [15:0] cnt_reg;
  logic        run_reg;

  // counter runs from start until the programmed count
  always_ff @(posedge mclk) begin
    done <= 1'b0;
    if (!nrst) begin
      cnt_reg <= 16'h0000;
      run_reg <= 1'b0;
    end else if (abort) begin
      run_reg <= 1'b0;
    end else if (start) begin
      cnt_reg <= 16'h0001;
      run_reg <= 1'b1;
    end else if (run_reg) begin
      if (cnt_reg == 16'(CYCLES)) begin
        run_reg <= 1'b0;
        done    <= 1'b1;
      end else begin
        cnt_reg <= cnt_reg + 16'h0001;
      end
    end
  end
endmodule // rfant_delay

// File: src/rfant_ctrl.sv
/*
  antenna diversity and rx/tx indicator control with register port.
  assumes radio status inputs from mclk logic; sleep_transmit_pin is a raw pin.
*/
// Implementation choice: the plain strobed port.
`timescale 1ns/1ps
`include "rfant_regs.svh"
module rfant_ctrl (
  input  wire logic                 mclk,               // 250 MHz clock
  input  wire logic                 nrst,               // sync reset, low
  input  wire rfant_pkg::rfant_addr_t addr,             // register address
  input  wire rfant_pkg::rfant_data_t wdata,            // write data
  input  wire logic                 wr,                 // write strobe
  input  wire logic                 rd,                 // read strobe
  output rfant_pkg::rfant_data_t    rdata,              // read data, next cycle
  input  wire logic                 sleep_transmit_pin, // raw pin, rising = tx
  input  wire logic                 pa_off,             // pulse, internal pa disabled
  input  wire logic                 in_rx_state,        // radio in a receive state
  input  wire logic                 pll_or_rx_on,       // radio in pll-on or rx-on
  input  wire logic                 shr_search_start,   // pulse, header search begins
  input  wire logic                 shr_found,          // pulse, header locked
  input  wire logic                 search_antenna,     // antenna being probed
  input  wire logic                 auto_ack_receive_mode,    // ack reply mode
  input  wire logic                 ack_tx_start,       // pulse, ack transmit begins
  input  wire logic                 auto_retry_transmit_mode, // retry mode
  input  wire logic                 retry_start,        // pulse, retry after missing ack
  input  wire logic                 timestamp_level,    // frame time stamp level
  output logic                      switch_pin_a,       // antenna switch pin a
  output logic                      switch_pin_b,       // antenna switch pin b
  output logic                      frontend_pin_a,     // indicator pin a
  output logic                      frontend_pin_b,     // indicator pin b
  output logic                      tx_indicated        // sequencer in tx or off-wait, pins enabled or not
);
  import rfant_pkg::*;

  localparam int TX_ON_CYC  = `RFANT_TX_ON_CYC;
  localparam int TX_OFF_CYC = `RFANT_TX_OFF_CYC;

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  logic [3:0] correlator_threshold;
  logic       auto_diversity_enable;
  logic       switch_drive_enable;
  logic [1:0] static_antenna_choice;
  logic       selected_antenna_flag;
  logic [7:0] transceiver_control_one;
  logic       frontend_indicator_enable;
  logic       timestamp_pin_enable;
  logic       auto_ant_reg;
  logic       auto_valid_reg;
  logic       static_wr;

  assign frontend_indicator_enable = transceiver_control_one[`RFANT_BIT_FEEN];
  assign timestamp_pin_enable      = transceiver_control_one[`RFANT_BIT_TSEN];
  assign static_wr = wr && (addr == `RFANT_OFS_ANTSEL);

  // software writes; device never adjusts threshold itself
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      correlator_threshold    <= `RFANT_THRES_RST;
      auto_diversity_enable   <= 1'b0;
      switch_drive_enable     <= 1'b0;
      static_antenna_choice   <= 2'b00;
      transceiver_control_one <= `RFANT_TRXCTL1_RST;
    end else if (wr) begin
      unique case (addr)
        `RFANT_OFS_RXCORR:  correlator_threshold <= wdata[3:0];
        `RFANT_OFS_ANTSEL: begin
          auto_diversity_enable <= wdata[`RFANT_BIT_DIVEN];
          switch_drive_enable   <= wdata[`RFANT_BIT_SWEN];
          static_antenna_choice <= wdata[1:0];
        end
        `RFANT_OFS_TRXCTL1: transceiver_control_one <= wdata;
        default: ;
      endcase
    end
  end

  // read mux, data one cycle after strobe
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      rdata <= 8'h00;
    end else if (rd) begin
      unique case (addr)
        `RFANT_OFS_RXCORR:  rdata <= {4'h0, correlator_threshold};
        `RFANT_OFS_ANTSEL:  rdata <= {selected_antenna_flag, 3'b000, auto_diversity_enable,
                                      switch_drive_enable, static_antenna_choice};
        `RFANT_OFS_TRXCTL1: rdata <= transceiver_control_one;
        `RFANT_OFS_STATUS:  rdata <= {6'h00, auto_valid_reg, tx_indicated};
        default:            rdata <= 8'h00;
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end

  // ------------------------------------------------------------
  // diversity antenna choice
  // ------------------------------------------------------------
  // algorithm choice: locked on header, ack/retry steering, dropped on exit
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      auto_ant_reg   <= 1'b0;
      auto_valid_reg <= 1'b0;
    end else if (!auto_diversity_enable) begin
      auto_valid_reg <= 1'b0;
    end else if (auto_retry_transmit_mode && retry_start) begin
      auto_ant_reg   <= ~auto_ant_reg;
      auto_valid_reg <= 1'b1;
    end else if (auto_ack_receive_mode && ack_tx_start) begin
      auto_valid_reg <= 1'b1;
    end else if (shr_found) begin
      auto_ant_reg   <= search_antenna;
      auto_valid_reg <= 1'b1;
    end else if (shr_search_start || !in_rx_state || static_wr) begin
      auto_valid_reg <= 1'b0;
    end
  end

  // reported antenna: header lock in auto mode, static choice otherwise
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      selected_antenna_flag <= 1'b0;
    end else if (auto_diversity_enable) begin
      if (shr_found) begin
        selected_antenna_flag <= search_antenna;
      end
    end else if (static_antenna_choice == 2'b01) begin
      selected_antenna_flag <= 1'b0;
    end else if (static_antenna_choice == 2'b10) begin
      selected_antenna_flag <= 1'b1;
    end
  end

  // switch pins, registered pair
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      switch_pin_a <= 1'b0;
      switch_pin_b <= 1'b0;
    end else if (!switch_drive_enable) begin
      switch_pin_a <= 1'b0;
      switch_pin_b <= timestamp_pin_enable ? timestamp_level : 1'b0;
    end else if (auto_diversity_enable) begin
      switch_pin_a <= auto_valid_reg ? auto_ant_reg : search_antenna;
      switch_pin_b <= timestamp_pin_enable ? timestamp_level
                    : ~(auto_valid_reg ? auto_ant_reg : search_antenna);
    end else if (pll_or_rx_on && (static_antenna_choice == 2'b01 ||
                                  static_antenna_choice == 2'b10)) begin
      switch_pin_a <= static_antenna_choice[1];
      switch_pin_b <= timestamp_pin_enable ? timestamp_level
                    : static_antenna_choice[0];
    end else if (timestamp_pin_enable) begin
      switch_pin_b <= timestamp_level;
    end
  end

  // ------------------------------------------------------------
  // rx/tx indicator
  // ------------------------------------------------------------
  logic      slp_s1_reg;
  logic      slp_s2_reg;
  logic      slp_d_reg;
  logic      tx_req;
  logic      on_done;
  logic      off_done;
  rfant_fe_e fe_reg;

  // pin synchroniser then edge detect on second stage
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      slp_s1_reg <= 1'b0;
      slp_s2_reg <= 1'b0;
      slp_d_reg  <= 1'b0;
    end else begin
      slp_s1_reg <= sleep_transmit_pin;
      slp_s2_reg <= slp_s1_reg;
      slp_d_reg  <= slp_s2_reg;
    end
  end
  assign tx_req = slp_s2_reg && !slp_d_reg;

  rfant_delay #(.CYCLES(TX_ON_CYC)) u_on_dly (
    .mclk  (mclk),
    .nrst  (nrst),
    .start (tx_req && fe_reg == RFANT_FE_IDLE),
    .abort (1'b0),
    .done  (on_done)
  );

  rfant_delay #(.CYCLES(TX_OFF_CYC)) u_off_dly (
    .mclk  (mclk),
    .nrst  (nrst),
    .start (pa_off && fe_reg == RFANT_FE_TX),
    .abort (1'b0),
    .done  (off_done)
  );

  // tx indication sequencing
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      fe_reg <= RFANT_FE_IDLE;
    end else begin
      unique case (fe_reg)
        RFANT_FE_IDLE:     if (tx_req) fe_reg <= RFANT_FE_ON_WAIT;
        RFANT_FE_ON_WAIT:  if (on_done) fe_reg <= RFANT_FE_TX;
        RFANT_FE_TX:       if (pa_off) fe_reg <= RFANT_FE_OFF_WAIT;
        RFANT_FE_OFF_WAIT: if (off_done) fe_reg <= RFANT_FE_IDLE;
      endcase
    end
  end

  // indicator pins, both from one registered decision
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      frontend_pin_a <= 1'b0;
      frontend_pin_b <= 1'b0;
      tx_indicated   <= 1'b0;
    end else begin
      tx_indicated <= (fe_reg == RFANT_FE_TX) || (fe_reg == RFANT_FE_OFF_WAIT);
      if (!frontend_indicator_enable) begin
        frontend_pin_a <= 1'b0;
        frontend_pin_b <= 1'b0;
      end else if (fe_reg == RFANT_FE_TX || fe_reg == RFANT_FE_OFF_WAIT) begin
        frontend_pin_a <= 1'b1;
        frontend_pin_b <= 1'b0;
      end else begin
        frontend_pin_a <= 1'b0;
        frontend_pin_b <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  logic [15:0] fe_wait_cnt;

  // cycles spent in the current delay state, for the timing checks
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      fe_wait_cnt <= 16'h0000;
    end else if (fe_reg == RFANT_FE_ON_WAIT || fe_reg == RFANT_FE_OFF_WAIT) begin
      fe_wait_cnt <= fe_wait_cnt + 16'h0001;
    end else begin
      fe_wait_cnt <= 16'h0000;
    end
  end

  // steps of the tx indication and of the autonomous switch drive
  sequence s_tx_req;
    tx_req && fe_reg == RFANT_FE_IDLE;
  endsequence

  sequence s_on_wait;
    fe_reg == RFANT_FE_ON_WAIT;
  endsequence

  sequence s_off_wait;
    fe_reg == RFANT_FE_OFF_WAIT;
  endsequence

  sequence s_auto_drive;
    switch_drive_enable && auto_diversity_enable && !timestamp_pin_enable;
  endsequence

  AST_THRES_RESET: assert property (@(posedge mclk) $fell(nrst) |=>
    correlator_threshold == 4'h7) else $error("threshold not seven after reset");
  AST_FE_OFF: assert property (@(posedge mclk) disable iff (!nrst)
    !frontend_indicator_enable |=> !frontend_pin_a && !frontend_pin_b)
    else $error("indicator pins not low when disabled");
  AST_SW_OFF: assert property (@(posedge mclk) disable iff (!nrst)
    !switch_drive_enable |=> !switch_pin_a)
    else $error("switch pin a not low when disabled");
  AST_TX_REQ: assert property (@(posedge mclk) disable iff (!nrst)
    s_tx_req |=> s_on_wait)
    else $error("tx request not taken");
  AST_TX_ON: assert property (@(posedge mclk) disable iff (!nrst)
    s_on_wait |=> (fe_reg == RFANT_FE_TX) == (fe_wait_cnt == 16'(TX_ON_CYC + 1)))
    else $error("tx pattern not reached on time");
  AST_TX_OFF: assert property (@(posedge mclk) disable iff (!nrst)
    s_off_wait |=> (fe_reg == RFANT_FE_IDLE) == (fe_wait_cnt == 16'(TX_OFF_CYC + 1)))
    else $error("rx pattern not restored on time");
  AST_FE_TX: assert property (@(posedge mclk) disable iff (!nrst)
    frontend_indicator_enable && fe_reg == RFANT_FE_TX |=> frontend_pin_a && !frontend_pin_b)
    else $error("indicator pair not in tx pattern");
  AST_SW_OFF_B: assert property (@(posedge mclk) disable iff (!nrst)
    !switch_drive_enable && !timestamp_pin_enable |=> !switch_pin_b)
    else $error("switch pin b not low when disabled");
  AST_AUTO_PIN: assert property (@(posedge mclk) disable iff (!nrst)
    s_auto_drive |=> switch_pin_a != switch_pin_b)
    else $error("switch pair not differential in auto mode");
  AST_RETRY: assert property (@(posedge mclk) disable iff (!nrst)
    auto_diversity_enable && auto_retry_transmit_mode && retry_start
    |=> auto_ant_reg != $past(auto_ant_reg))
    else $error("retry did not alternate the antenna");
  AST_ACK: assert property (@(posedge mclk) disable iff (!nrst)
    auto_diversity_enable && auto_ack_receive_mode && ack_tx_start && !retry_start
    |=> auto_valid_reg && $stable(auto_ant_reg))
    else $error("ack not sent on the receive antenna");
  AST_SEL_LOCK: assert property (@(posedge mclk) disable iff (!nrst)
    auto_diversity_enable && shr_found |=> selected_antenna_flag == $past(search_antenna))
    else $error("selected antenna not updated on header");
  AST_SEL_STATIC: assert property (@(posedge mclk) disable iff (!nrst)
    !auto_diversity_enable && static_antenna_choice == 2'b10 |=> selected_antenna_flag)
    else $error("selected antenna not following static choice");
  AST_HOLD_OFF: assert property (@(posedge mclk) disable iff (!nrst)
    switch_drive_enable && !auto_diversity_enable && !pll_or_rx_on && !timestamp_pin_enable
    |=> $stable({switch_pin_a, switch_pin_b}))
    else $error("static choice reached pins outside pll-on and rx-on");
  AST_VALID_DROP: assert property (@(posedge mclk) disable iff (!nrst)
    auto_diversity_enable && !in_rx_state && !shr_found && !retry_start && !ack_tx_start
    |=> !auto_valid_reg)
    else $error("auto choice kept after leaving receive");
  AST_FE_PAIR: assert property (@(posedge mclk) disable iff (!nrst)
    frontend_indicator_enable && $past(frontend_indicator_enable) |-> frontend_pin_a != frontend_pin_b)
    else $error("indicator pair not differential");
  AST_SEL_HOLD: assert property (@(posedge mclk) disable iff (!nrst)
    auto_diversity_enable && !shr_found |=> $stable(selected_antenna_flag))
    else $error("selected antenna changed without header");
  AST_STATIC: assert property (@(posedge mclk) disable iff (!nrst)
    switch_drive_enable && !auto_diversity_enable && pll_or_rx_on && !timestamp_pin_enable
    && static_antenna_choice == 2'b01 && !wr |=> !switch_pin_a && switch_pin_b)
    else $error("static antenna 0 pattern wrong");
  AST_TS: assert property (@(posedge mclk) disable iff (!nrst)
    timestamp_pin_enable |=> switch_pin_b == $past(timestamp_level))
    else $error("switch pin b not carrying time stamp");
endmodule // rfant_ctrl

// File: verif/rfant_fe_model.sv
/*
  model of the external antenna switch and rf front-end amplifiers.
  assumes the switch and indicator pairs come straight from rfant_ctrl.
*/
`timescale 1ns/1ps
module rfant_fe_model (
  input  wire logic mclk,     // clock
  input  wire logic sw_a,     // switch control a
  input  wire logic sw_b,     // switch control b
  input  wire logic fe_a,     // indicator a
  input  wire logic fe_b,     // indicator b
  output logic      ant_one,  // antenna 1 connected
  output logic      amp_on,   // tx amplifier path on
  output logic      pair_bad  // both lines of a pair high
);
  // decode the differential pairs as the switch and amplifier see them
  always_ff @(posedge mclk) begin
    ant_one  <= sw_a & ~sw_b;
    amp_on   <= fe_a & ~fe_b;
    pair_bad <= (sw_a & sw_b) | (fe_a & fe_b);
  end
endmodule // rfant_fe_model

// File: verif/rfant_ctrl_tb.sv
/*
  self-checking bench of rfant_ctrl: registers, static and autonomous antenna
  choice, time stamp sharing, indicator timing. assumes a 250 MHz mclk.
*/
`timescale 1ns/1ps
`include "rfant_regs.svh"
module rfant_ctrl_tb;
  import rfant_pkg::*;
  logic        mclk = 0, nrst = 0, wr = 0, rd = 0;
  rfant_addr_t addr = '0;
  rfant_data_t wdata = '0, rdata, v;
  logic        stp = 0, pa_off = 0, pll_on = 1, srch = 0, found = 0, sant = 0, ts = 0, e;
  logic        rxs = 1, aam = 0, ack = 0, arm = 0, rty = 0;
  logic        swa, swb, fea, feb, txi, ant_one, amp_on, pair_bad;
  int          err_count = 0, total_checks = 0, cyc = 0, n;
  logic [31:0] rs = 32'h0000_0013;
  // --------------------------------------------------------
  // clock, design, partner
  // --------------------------------------------------------
  always #2 mclk = ~mclk;
  rfant_ctrl rfant_ctrl_i (.mclk(mclk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .sleep_transmit_pin(stp), .pa_off(pa_off), .in_rx_state(rxs),
    .pll_or_rx_on(pll_on), .shr_search_start(srch), .shr_found(found), .search_antenna(sant),
    .auto_ack_receive_mode(aam), .ack_tx_start(ack), .auto_retry_transmit_mode(arm),
    .retry_start(rty), .timestamp_level(ts), .switch_pin_a(swa), .switch_pin_b(swb),
    .frontend_pin_a(fea), .frontend_pin_b(feb), .tx_indicated(txi));
  rfant_fe_model rfant_fe_model_i (.mclk(mclk), .sw_a(swa), .sw_b(swb), .fe_a(fea),
    .fe_b(feb), .ant_one(ant_one), .amp_on(amp_on), .pair_bad(pair_bad));
  // --------------------------------------------------------
  // helpers
  // --------------------------------------------------------
  function automatic logic rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs[0];
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wreg(input rfant_addr_t a, input rfant_data_t d);
    @(posedge mclk) begin addr <= a; wdata <= d; wr <= 1'b1; end
    @(posedge mclk) wr <= 1'b0;
  endtask
  task automatic rreg(input rfant_addr_t a);
    @(posedge mclk) begin addr <= a; rd <= 1'b1; end
    @(posedge mclk) rd <= 1'b0;
    #1 v = rdata;
  endtask
  // one-cycle pulse: 0 search, 1 found, 2 pa off, 3 retry, 4 ack
  task automatic pulse(input int w);
    @(posedge mclk) begin
      srch   <= (w == 0);
      found  <= (w == 1);
      pa_off <= (w == 2);
      rty    <= (w == 3);
      ack    <= (w == 4);
    end
    @(posedge mclk) begin
      srch   <= 1'b0;
      found  <= 1'b0;
      pa_off <= 1'b0;
      rty    <= 1'b0;
      ack    <= 1'b0;
    end
  endtask
  task automatic settle();
    repeat (3) @(posedge mclk);
    #1;
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // hang guard
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      test_done();
    end
  end
  // --------------------------------------------------------
  // main sequence
  // --------------------------------------------------------
  initial begin
    repeat (20) @(posedge mclk);
    nrst <= 1'b1;
    rreg(`RFANT_OFS_RXCORR);  chk(v, `RFANT_THRES_RST);
    rreg(`RFANT_OFS_ANTSEL);  chk(v, 8'h00);
    rreg(`RFANT_OFS_TRXCTL1); chk(v, `RFANT_TRXCTL1_RST);
    rreg(8'h33);              chk(v, 8'h00);
    wreg(`RFANT_OFS_ANTSEL, 8'hf5);
    rreg(`RFANT_OFS_ANTSEL);  chk(v, 8'h05);
    // reset in mid-run brings back the reset values
    wreg(`RFANT_OFS_RXCORR, 8'h03);
    @(posedge mclk) nrst <= 1'b0;
    repeat (3) @(posedge mclk);
    nrst <= 1'b1;
    rreg(`RFANT_OFS_RXCORR);  chk(v, `RFANT_THRES_RST);
    rreg(`RFANT_OFS_ANTSEL);  chk(v, 8'h00);
    $display("test registers done");
    // static choice both antennas, then drive disabled
    for (int c = 1; c < 3; c++) begin
      wreg(`RFANT_OFS_ANTSEL, 8'h04 | 8'(c));
      settle();
      chk(8'({swa, swb}), (c == 1) ? 8'h01 : 8'h02);
      chk(8'(ant_one), 8'(c == 2));
      rreg(`RFANT_OFS_ANTSEL); chk(v, {c == 2, 3'h0, 4'h4 | 4'(c)});
    end
    @(posedge mclk) pll_on <= 1'b0;
    wreg(`RFANT_OFS_ANTSEL, 8'h05);
    settle(); chk(8'({swa, swb}), 8'h02);
    @(posedge mclk) pll_on <= 1'b1;
    settle(); chk(8'({swa, swb}), 8'h01);
    wreg(`RFANT_OFS_ANTSEL, 8'h01);
    settle(); chk(8'({swa, swb}), 8'h00);
    // time stamp takes over pin b
    wreg(`RFANT_OFS_TRXCTL1, 8'h62);
    wreg(`RFANT_OFS_ANTSEL, 8'h06);
    for (int k = 0; k < 8; k++) begin
      @(posedge mclk) ts <= rnd();
      repeat (2) @(posedge mclk);
      #1 chk(8'(swb), 8'(ts));
    end
    wreg(`RFANT_OFS_TRXCTL1, `RFANT_TRXCTL1_RST);
    $display("test static choice done");
    // autonomous diversity, threshold set by software
    wreg(`RFANT_OFS_RXCORR, 8'(`RFANT_THRES_DIV));
    wreg(`RFANT_OFS_ANTSEL, 8'h0c);
    for (int k = 0; k < 6; k++) begin
      e = rnd();
      @(posedge mclk) sant <= e;
      pulse(0);
      pulse(1);
      @(posedge mclk) sant <= ~e;
      settle(); chk(8'({swa, swb}), 8'({e, ~e}));
      rreg(`RFANT_OFS_ANTSEL); chk(v, {e, 7'h0c});
    end
    // leaving receive drops the lock, retries alternate, ack steers back
    @(posedge mclk) rxs <= 1'b0;
    settle(); chk(8'({swa, swb}), 8'({~e, e}));
    @(posedge mclk) begin rxs <= 1'b1; arm <= 1'b1; sant <= e; end
    for (int k = 0; k < 2; k++) begin
      pulse(3);
      settle(); chk(8'({swa, swb}), (k == 0) ? 8'({~e, e}) : 8'({e, ~e}));
    end
    @(posedge mclk) begin arm <= 1'b0; aam <= 1'b1; sant <= ~e; end
    pulse(0);
    settle(); chk(8'({swa, swb}), 8'({~e, e}));
    pulse(4);
    settle(); chk(8'({swa, swb}), 8'({e, ~e}));
    @(posedge mclk) aam <= 1'b0;
    wreg(`RFANT_OFS_RXCORR, 8'(`RFANT_THRES_RST));
    rreg(`RFANT_OFS_RXCORR); chk(v, 8'h07);
    wreg(`RFANT_OFS_ANTSEL, 8'h00);
    $display("test diversity done");
    // indicator pair around two transmissions
    wreg(`RFANT_OFS_TRXCTL1, 8'ha2);
    settle(); chk(8'({fea, feb}), 8'h01);
    for (int t = 0; t < 2; t++) begin
      @(posedge mclk) stp <= 1'b1;
      n = 0;
      while (txi !== 1'b1 && n < 2000) begin @(posedge mclk); #1 n++; end
      chk(8'(n >= `RFANT_TX_ON_CYC && n <= `RFANT_TX_ON_CYC + 10), 8'h01);
      settle(); chk(8'({fea, feb, amp_on, pair_bad}), 8'h0a);
      rreg(`RFANT_OFS_STATUS); chk(v, 8'h01);
      @(posedge mclk) stp <= 1'b0;
      pulse(2);
      n = 0;
      while (txi !== 1'b0 && n < 2000) begin @(posedge mclk); #1 n++; end
      chk(8'(n >= `RFANT_TX_OFF_CYC - 2 && n <= `RFANT_TX_OFF_CYC + 10), 8'h01);
      settle(); chk(8'({fea, feb}), 8'h01);
    end
    wreg(`RFANT_OFS_TRXCTL1, `RFANT_TRXCTL1_RST);
    settle(); chk(8'({fea, feb}), 8'h00);
    $display("test indicator done");
    test_done();
  end
endmodule // rfant_ctrl_tb
